// ===== oscsd_consts.vh
// constants for the oscillator select, doze and module gating block
// assumes a 32-bit classic wishbone slave, word aligned registers
//
// Contract
// - active source shown read-only in a 3-bit field, fixed encoding
// - requested source writable in bits 10-8, reset from configuration bits
// - switch request bit stays 1 while pending, reads 0 when done
// - clock lock plus config bit set refuses clock and pll changes
// - pin map lock bit at bit 6, writable, drives the io lock
// - pll lock bit reads 1 when locked or start-up timer expired
// - fail flag set by monitor; software one forces failure trap
// - oscillator control writes need an unlock sequence first
// - doze slows only the cpu clock; peripherals keep full speed
// - doze enabled by bit 11 of clock divider register
// - doze ratio bits 14-12 select 1:1 to 1:128, default 1:1
// - recover on interrupt bit 15 returns cpu to full speed
// - module disable stops module clocks; its registers ignore access
// - module runs only when disable bit clear and module present
// - disable and enable take effect one instruction cycle later
// - oscillator control bits 15, 11, 4, 2, 1 read zero
`ifndef OSCSD_CONSTS_VH
`define OSCSD_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OSCSD_ADR_OSC_CTRL   8'h00
`define OSCSD_ADR_CLK_DIV    8'h04
`define OSCSD_ADR_MOD_DIS    8'h08
`define OSCSD_ADR_UNLOCK     8'h0C
`define OSCSD_ADR_IRQ_STAT   8'h10
`define OSCSD_ADR_IRQ_MASK   8'h14

// ----------------------------------------------------------------
// oscillator control fields
// ----------------------------------------------------------------
`define OSCSD_ACT_LSB        12
`define OSCSD_REQ_LSB        8
`define OSCSD_CLK_LOCK_BIT   7
`define OSCSD_PIN_LOCK_BIT   6
`define OSCSD_PLL_LOCK_BIT   5
`define OSCSD_FAIL_BIT       3
`define OSCSD_SWITCH_BIT     0
`define OSCSD_OSC_WMASK      16'h07C9

// ----------------------------------------------------------------
// clock divider fields
// ----------------------------------------------------------------
`define OSCSD_ROI_BIT        15
`define OSCSD_DOZE_LSB       12
`define OSCSD_DOZE_EN_BIT    11
`define OSCSD_DIV_WMASK      16'hF800

// ----------------------------------------------------------------
// source codes
// ----------------------------------------------------------------
`define OSCSD_SRC_FRC        3'h0
`define OSCSD_SRC_FRC_PLL    3'h1
`define OSCSD_SRC_PRI        3'h2
`define OSCSD_SRC_PRI_PLL    3'h3
`define OSCSD_SRC_RSVD       3'h4
`define OSCSD_SRC_LOW_POWER_RC_OSCILLATOR       3'h5
`define OSCSD_SRC_FRC_D16    3'h6
`define OSCSD_SRC_FRC_DN     3'h7

// ----------------------------------------------------------------
// unlock keys and timing
// ----------------------------------------------------------------
`define OSCSD_KEY_FIRST      8'h55
`define OSCSD_KEY_SECOND     8'hAA
`define OSCSD_UNLOCK_WINDOW  4'h4
`define OSCSD_SWITCH_NS      1000
`define OSCSD_CLK_NS         100
// switch time in clk_i cycles, sized to the switch counter (1000 ns at 100 ns)
`define OSCSD_SWITCH_CYC     8'd10

`endif

// ===== oscsd_doze_div.v
// cpu clock enable divider for doze mode
// assumes clk_i is the system clock that peripherals keep using
`timescale 1ns/10ps
module oscsd_doze_div (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       doze_active_i,
  input  wire [2:0] ratio_i,
  output reg        cpu_tick_o
);

  reg [6:0] count;

  // ----------------------------------------------------------------
  // divide-by-2^n tick
  // ----------------------------------------------------------------
  function [6:0] oscsd_limit;
    input [2:0] n;
    begin
      oscsd_limit = (7'h01 << n) - 7'h01;
    end
  endfunction

  // tick stays phase locked to clk_i so the two domains never drift
  always @(posedge clk_i) begin
    if (rst_i) begin
      count      <= 7'h00;
      cpu_tick_o <= 1'b1;
    end else if (!doze_active_i) begin
      count      <= 7'h00;
      cpu_tick_o <= 1'b1;
    end else if (count >= oscsd_limit(ratio_i)) begin
      count      <= 7'h00;
      cpu_tick_o <= 1'b1;
    end else begin
      count      <= count + 7'h01;
      cpu_tick_o <= 1'b0;
    end
  end

endmodule // oscsd_doze_div

// ===== oscsd_gate.v
// per-module enable with one instruction cycle of delay
// assumes instr_tick_i marks the end of each instruction cycle
`timescale 1ns/10ps
module oscsd_gate #(
  parameter N = 5
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         instr_tick_i,
  input  wire [N-1:0] disable_i,
  input  wire [N-1:0] present_i,
  output reg  [N-1:0] enable_o
);

  reg [N-1:0] pend;

  // ----------------------------------------------------------------
  // delayed enable
  // ----------------------------------------------------------------
  // a bit change is captured, then applied at the next instruction end
  always @(posedge clk_i) begin
    if (rst_i) begin
      pend     <= {N{1'b0}};
      enable_o <= {N{1'b0}};
    end else begin
      pend <= ~disable_i & present_i;
      if (instr_tick_i) begin
        enable_o <= pend;
      end
    end
  end

endmodule // oscsd_gate

// ===== oscsd_top.v
// oscillator select, doze and module clock gating with a wishbone slave
// assumes config lock, pll lock, pll timer, monitor and interrupt inputs come from pins
`timescale 1ns/10ps
`include "oscsd_consts.vh"
module oscsd_top #(
  parameter       NMOD        = 5,
  parameter [2:0] CFG_SRC     = 3'h0,
  parameter [NMOD-1:0] PRESENT = {NMOD{1'b1}}
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  input  wire        cfg_switch_lock_i,
  input  wire        pll_locked_i,
  input  wire        pll_timer_done_i,
  input  wire        monitor_fail_i,
  input  wire        cpu_irq_i,
  output reg  [2:0]  clk_source_o,
  output reg         pin_map_lock_o,
  output reg         osc_fail_trap_o,
  output reg         cpu_clk_en_o,
  output reg  [NMOD-1:0] module_clk_en_o,
  output reg         irq_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] sync_lock;
  reg [1:0] sync_timer;
  reg [1:0] sync_fail;
  reg [1:0] sync_cfg;
  reg [1:0] sync_irq;

  // two flops per pin, only the second is read by logic
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_lock  <= 2'h0;
      sync_timer <= 2'h0;
      sync_fail  <= 2'h0;
      sync_cfg   <= 2'h0;
      sync_irq   <= 2'h0;
    end else begin
      sync_lock  <= {sync_lock[0], pll_locked_i};
      sync_timer <= {sync_timer[0], pll_timer_done_i};
      sync_fail  <= {sync_fail[0], monitor_fail_i};
      sync_cfg   <= {sync_cfg[0], cfg_switch_lock_i};
      sync_irq   <= {sync_irq[0], cpu_irq_i};
    end
  end

  wire pll_ok   = sync_lock[1] | sync_timer[1];
  wire cfg_lock = sync_cfg[1];
  wire irq_in   = sync_irq[1];
  wire fail_in  = sync_fail[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [2:0]      active_clock_source;
  reg [2:0]      requested_clock_source;
  reg            switch_request;
  reg            clock_config_lock;
  reg            pin_map_lock;
  reg            clock_fail_flag;
  reg            recover_on_interrupt;
  reg [2:0]      doze_ratio;
  reg            doze_enable;
  reg [NMOD-1:0] module_disable;
  reg [1:0]      irq_status;
  reg [1:0]      irq_mask;
  reg [1:0]      unlock_state;
  reg [3:0]      unlock_timer;
  reg [7:0]      switch_count;
  reg            loaded;
  reg            fail_prev;
  reg            switch_done_ev;

  function [15:0] oscsd_merge;
    input [15:0] old_val;
    input [15:0] new_val;
    input [3:0]  sel;
    begin
      oscsd_merge[7:0]  = sel[0] ? new_val[7:0]  : old_val[7:0];
      oscsd_merge[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        req      = cyc_i & stb_i & ~ack_o;
  wire        wr       = req & we_i;
  wire        wr_osc   = wr & (adr_i == `OSCSD_ADR_OSC_CTRL);
  wire        wr_div   = wr & (adr_i == `OSCSD_ADR_CLK_DIV);
  wire        wr_mod   = wr & (adr_i == `OSCSD_ADR_MOD_DIS);
  wire        wr_key   = wr & (adr_i == `OSCSD_ADR_UNLOCK) & sel_i[0];
  wire        wr_stat  = wr & (adr_i == `OSCSD_ADR_IRQ_STAT);
  wire        wr_mask  = wr & (adr_i == `OSCSD_ADR_IRQ_MASK);
  wire        unlocked = (unlock_state == 2'h2);
  wire        osc_ok   = wr_osc & unlocked;
  wire        locked   = clock_config_lock & cfg_lock;

  wire [15:0] osc_view;
  assign osc_view = {1'b0, active_clock_source, 1'b0, requested_clock_source,
                     clock_config_lock, pin_map_lock, pll_ok, 1'b0,
                     clock_fail_flag, 2'b00, switch_request};
  wire [15:0] div_view = {recover_on_interrupt, doze_ratio, doze_enable, 11'h000};
  wire [15:0] osc_new  = oscsd_merge(osc_view, dat_i[15:0], sel_i);
  wire [15:0] div_new  = oscsd_merge(div_view, dat_i[15:0], sel_i) & `OSCSD_DIV_WMASK;

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  // key pair opens a short window for exactly one control write
  always @(posedge clk_i) begin
    if (rst_i) begin
      unlock_state <= 2'h0;
      unlock_timer <= 4'h0;
    end else if (wr_osc) begin
      unlock_state <= 2'h0;
    end else if (wr_key && dat_i[7:0] == `OSCSD_KEY_FIRST) begin
      unlock_state <= 2'h1;
    end else if (wr_key && unlock_state == 2'h1 && dat_i[7:0] == `OSCSD_KEY_SECOND) begin
      unlock_state <= 2'h2;
      unlock_timer <= `OSCSD_UNLOCK_WINDOW;
    end else if (wr_key) begin
      unlock_state <= 2'h0;
    end else if (unlock_state == 2'h2) begin
      if (unlock_timer == 4'h0) begin
        unlock_state <= 2'h0;
      end else begin
        unlock_timer <= unlock_timer - 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // oscillator control and switch
  // ----------------------------------------------------------------
  // the requested source is loaded from straps one cycle after reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      active_clock_source    <= `OSCSD_SRC_FRC;
      requested_clock_source <= `OSCSD_SRC_FRC;
      switch_request         <= 1'b0;
      clock_config_lock      <= 1'b0;
      pin_map_lock           <= 1'b0;
      switch_count           <= 8'h00;
      loaded                 <= 1'b0;
      switch_done_ev         <= 1'b0;
    end else begin
      switch_done_ev <= 1'b0;
      if (!loaded) begin
        loaded                 <= 1'b1;
        requested_clock_source <= CFG_SRC;
        active_clock_source    <= CFG_SRC;
      end else if (osc_ok) begin
        if (sel_i[0]) begin
          pin_map_lock      <= osc_new[`OSCSD_PIN_LOCK_BIT];
          clock_config_lock <= osc_new[`OSCSD_CLK_LOCK_BIT];
        end
        if (!locked) begin
          requested_clock_source <= osc_new[10:8];
          if (sel_i[0] && osc_new[`OSCSD_SWITCH_BIT] && !switch_request) begin
            switch_request <= 1'b1;
            switch_count   <= `OSCSD_SWITCH_CYC;
          end
        end
      end else if (switch_request) begin
        if (switch_count != 8'h00) begin
          switch_count <= switch_count - 8'h01;
        end else if (requested_clock_source == `OSCSD_SRC_RSVD) begin
          switch_request <= 1'b0; // reserved code is abandoned, source kept
        end else if ((requested_clock_source != `OSCSD_SRC_PRI_PLL &&
                      requested_clock_source != `OSCSD_SRC_FRC_PLL) || pll_ok) begin
          active_clock_source <= requested_clock_source;
          switch_request      <= 1'b0;
          switch_done_ev      <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // clock fail flag
  // ----------------------------------------------------------------
  // a monitor edge or a software one sets it; the set beats a clear
  wire fail_set = (fail_in & ~fail_prev) |
                  (osc_ok & sel_i[0] & osc_new[`OSCSD_FAIL_BIT]);
  always @(posedge clk_i) begin
    if (rst_i) begin
      clock_fail_flag <= 1'b0;
      fail_prev       <= 1'b0;
      osc_fail_trap_o <= 1'b0;
    end else begin
      fail_prev       <= fail_in;
      osc_fail_trap_o <= fail_set;
      if (fail_set) begin
        clock_fail_flag <= 1'b1;
      end else if (osc_ok && sel_i[0]) begin
        clock_fail_flag <= osc_new[`OSCSD_FAIL_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // clock divider and module disable
  // ----------------------------------------------------------------
  // an interrupt only cancels doze when recover is armed
  always @(posedge clk_i) begin
    if (rst_i) begin
      recover_on_interrupt <= 1'b0;
      doze_ratio           <= 3'h0;
      doze_enable          <= 1'b0;
      module_disable       <= {NMOD{1'b0}};
    end else begin
      if (wr_div) begin
        recover_on_interrupt <= div_new[`OSCSD_ROI_BIT];
        doze_ratio           <= div_new[14:12];
        doze_enable          <= div_new[`OSCSD_DOZE_EN_BIT];
      end else if (recover_on_interrupt && irq_in && doze_enable) begin
        doze_enable <= 1'b0;
      end
      if (wr_mod && sel_i[0]) begin
        module_disable <= dat_i[NMOD-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // doze divider and module gating
  // ----------------------------------------------------------------
  wire             cpu_tick;
  wire [NMOD-1:0]  gate_en;

  oscsd_doze_div u_doze (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .doze_active_i (doze_enable),
    .ratio_i       (doze_ratio),
    .cpu_tick_o    (cpu_tick)
  );

  oscsd_gate #(.N(NMOD)) u_gate (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .instr_tick_i (cpu_tick),
    .disable_i    (module_disable),
    .present_i    (PRESENT),
    .enable_o     (gate_en)
  );

  // ----------------------------------------------------------------
  // interrupt status: bit0 switch done, bit1 clock fail
  // ----------------------------------------------------------------
  wire [1:0] irq_set = {fail_set, switch_done_ev};
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= 2'h0;
      irq_mask   <= 2'h0;
    end else begin
      irq_status <= irq_set | (irq_status & ~(wr_stat & sel_i[0] ? dat_i[1:0] : 2'h0));
      if (wr_mask && sel_i[0]) begin
        irq_mask <= dat_i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, ack and registered outputs
  // ----------------------------------------------------------------
  // unmapped addresses ack with zero so the master never hangs
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o           <= 1'b0;
      dat_o           <= 32'h00000000;
      clk_source_o    <= `OSCSD_SRC_FRC;
      pin_map_lock_o  <= 1'b0;
      cpu_clk_en_o    <= 1'b1;
      module_clk_en_o <= {NMOD{1'b0}};
      irq_o           <= 1'b0;
    end else begin
      ack_o <= req;
      dat_o <= 32'h00000000;
      if (req && !we_i) begin
        case (adr_i)
          `OSCSD_ADR_OSC_CTRL: dat_o <= {16'h0000, osc_view};
          `OSCSD_ADR_CLK_DIV:  dat_o <= {16'h0000, div_view};
          `OSCSD_ADR_MOD_DIS:  dat_o <= {{(32-NMOD){1'b0}}, module_disable};
          `OSCSD_ADR_IRQ_STAT: dat_o <= {30'h00000000, irq_status};
          `OSCSD_ADR_IRQ_MASK: dat_o <= {30'h00000000, irq_mask};
          default:             dat_o <= 32'h00000000;
        endcase
      end
      clk_source_o    <= active_clock_source;
      pin_map_lock_o  <= pin_map_lock;
      cpu_clk_en_o    <= cpu_tick;
      module_clk_en_o <= gate_en;
      irq_o           <= |(irq_status & irq_mask);
    end
  end

endmodule // oscsd_top

// ===== oscsd_checker.sv
// assertions on the ports of the oscillator select block
// assumes it is bound to oscsd_top, one clock, synchronous reset
`timescale 1ns/10ps
module oscsd_checker #(
  parameter            NMOD    = 5,
  parameter [NMOD-1:0] PRESENT = {NMOD{1'b1}}
) (
  input wire            clk_i,
  input wire            rst_i,
  input wire            cyc_i,
  input wire            stb_i,
  input wire            we_i,
  input wire [7:0]      adr_i,
  input wire [31:0]     dat_o,
  input wire            ack_o,
  input wire            osc_fail_trap_o,
  input wire            cpu_clk_en_o,
  input wire [NMOD-1:0] module_clk_en_o,
  input wire            irq_o
);
  // ------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // every taken request is answered on the next edge
  AST_ACK_TAKEN: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not answered");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  AST_HI_ZERO: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper half of read data not zero");
  AST_OSC_RSVD: assert property (ack_o && $past(adr_i == 8'h00 && !we_i) |-> (dat_o & 32'h00008816) == 32'h0)
    else $error("unused control bits read nonzero");
  AST_TRAP_PULSE: assert property (osc_fail_trap_o |=> !osc_fail_trap_o)
    else $error("trap pulse too long");
  // slowest doze ratio still ticks once in 128 cycles
  AST_CPU_TICK: assert property (!cpu_clk_en_o |-> ##[1:128] cpu_clk_en_o)
    else $error("cpu tick gap beyond 128 cycles");
  // interrupt only drops after software touched status or mask
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> $past(we_i, 1) || $past(we_i, 2) || $past(we_i, 3))
    else $error("interrupt dropped without a write");
  AST_MOD_RESET: assert property ($fell(rst_i) |-> ##[1:6] module_clk_en_o == PRESENT)
    else $error("present modules not enabled after reset");
  AST_MOD_ABSENT: assert property ((module_clk_en_o & ~PRESENT) == {NMOD{1'b0}})
    else $error("absent module clock enabled");
  AST_CPU_RST: assert property ($fell(rst_i) |-> cpu_clk_en_o)
    else $error("cpu clock slowed out of reset");
endmodule // oscsd_checker

bind oscsd_top oscsd_checker #(.NMOD(NMOD), .PRESENT(PRESENT)) i_oscsd_checker (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .osc_fail_trap_o(osc_fail_trap_o), .cpu_clk_en_o(cpu_clk_en_o),
  .module_clk_en_o(module_clk_en_o), .irq_o(irq_o)
);

// ===== testbench.sv
// self-checking bench for the oscillator select block
// assumes oscsd_top with a classic wishbone slave acking in one cycle
`timescale 1ns/10ps
module testbench;
  localparam       NM  = 5;
  localparam [4:0] PRS = 5'h17; // module 3 absent
  localparam [2:0] CFG = 3'h2;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic        cfg_lock = 1'b0;
  logic        pll_lk = 1'b0;
  logic        pll_tm = 1'b0;
  logic        mon_fail = 1'b0;
  logic        cpu_irq = 1'b0;
  wire  [31:0] dat_o;
  wire         ack_o;
  wire  [2:0]  clk_source_o;
  wire         pin_map_lock_o;
  wire         osc_fail_trap_o;
  wire         cpu_clk_en_o;
  wire  [NM-1:0] module_clk_en_o;
  wire         irq_o;
  int          err_count = 0;
  int          checks = 0;
  int          trap_cnt = 0;
  int          cyc_cnt = 0;

  oscsd_top #(.NMOD(NM), .CFG_SRC(CFG), .PRESENT(PRS)) i_oscsd_top (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'h3), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cfg_switch_lock_i(cfg_lock),
    .pll_locked_i(pll_lk), .pll_timer_done_i(pll_tm), .monitor_fail_i(mon_fail), .cpu_irq_i(cpu_irq),
    .clk_source_o(clk_source_o), .pin_map_lock_o(pin_map_lock_o), .osc_fail_trap_o(osc_fail_trap_o),
    .cpu_clk_en_o(cpu_clk_en_o), .module_clk_en_o(module_clk_en_o), .irq_o(irq_o));

  // ------------------------------------------------------------
  // clock, trap counter and hang guard
  // ------------------------------------------------------------
  always #50 clk_i = ~clk_i;
  // a hang anywhere ends the run as a failure
  always @(posedge clk_i) begin
    if (osc_fail_trap_o === 1'b1) trap_cnt <= trap_cnt + 1;
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_count++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
    end
  endtask
  // request held until ack is sampled, then a one cycle gap
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    q = dat_o;
    chk({31'h0, ack_o}, 32'h1, "bus answer");
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic osc_wr(input logic [15:0] v);
    wr(8'h0C, 32'h55);
    wr(8'h0C, 32'hAA);
    wr(8'h00, {16'h0, v});
  endtask
  task automatic switch_to(input logic [2:0] s, input logic [2:0] e);
    logic [31:0] q;
    int n;
    osc_wr({5'h00, s, 8'h01});
    rd(8'h00, q);
    if (s != 3'h4) chk({31'h0, q[0]}, 32'h1, "switch pending");
    for (n = 0; q[0] === 1'b1 && n < 40; n++) rd(8'h00, q);
    chk(q, {17'h0, e, 1'b0, s, 8'h20}, "switch done");
    chk({29'h0, clk_source_o}, {29'h0, e}, "source pin");
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    rd(8'h00, q);
    chk(q, {17'h0, CFG, 1'b0, CFG, 8'h00}, "control after reset");
    rd(8'h04, q);
    chk(q, 32'h0, "divider after reset");
    chk({27'h0, module_clk_en_o}, {27'h0, PRS}, "modules after reset");
    wr(8'h00, 32'h0101); // no unlock, must be dropped
    rd(8'h00, q);
    chk(q, {17'h0, CFG, 1'b0, CFG, 8'h00}, "locked write");
    wr(8'h20, 32'hFFFF);
    rd(8'h20, q);
    chk(q, 32'h0, "unmapped read");
  endtask
  // order avoids direct moves between the two pll modes
  task automatic t_switch();
    logic [2:0] seq [8] = '{3'h1, 3'h0, 3'h3, 3'h2, 3'h5, 3'h6, 3'h7, 3'h4};
    pll_lk <= 1'b1;
    foreach (seq[i]) switch_to(seq[i], (seq[i] == 3'h4) ? 3'h7 : seq[i]);
  endtask
  task automatic t_lock();
    logic [31:0] q;
    cfg_lock <= 1'b1;
    osc_wr(16'h00C0);
    chk({31'h0, pin_map_lock_o}, 32'h1, "pin lock set");
    osc_wr(16'h03C1);
    rd(8'h00, q);
    chk(q, 32'h70E0, "locked switch refused");
    cfg_lock <= 1'b0;
    repeat (3) @(posedge clk_i);
    switch_to(3'h0, 3'h0);
    chk({31'h0, pin_map_lock_o}, 32'h0, "pin lock clear");
    osc_wr(16'h8816);
    rd(8'h00, q);
    chk(q, 32'h0020, "unused bits ignored");
  endtask
  task automatic t_pll();
    logic [31:0] q;
    for (int i = 0; i < 4; i++) begin
      {pll_lk, pll_tm} <= i[1:0];
      repeat (4) @(posedge clk_i);
      rd(8'h00, q);
      chk({31'h0, q[5]}, {31'h0, i != 0}, "pll lock bit");
    end
  endtask
  task automatic t_fail();
    logic [31:0] q;
    int n0;
    n0 = trap_cnt;
    mon_fail <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(trap_cnt - n0, 32'h1, "monitor trap");
    rd(8'h00, q);
    chk({31'h0, q[3]}, 32'h1, "fail flag set");
    osc_wr(16'h0000);
    rd(8'h00, q);
    chk({31'h0, q[3]}, 32'h0, "fail flag cleared");
    osc_wr(16'h0008);
    repeat (3) @(posedge clk_i);
    chk(trap_cnt - n0, 32'h2, "software trap");
    osc_wr(16'h0000);
    mon_fail <= 1'b0;
  endtask
  // status bits 0 and 1 are pending; a mask bit of one lets its status through
  task automatic t_irq();
    logic [31:0] q;
    chk({31'h0, irq_o}, 32'h0, "irq masked after reset");
    wr(8'h14, 32'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1, "irq raised");
    rd(8'h10, q);
    chk(q, 32'h3, "status sticky");
    wr(8'h14, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0, "irq masked");
    wr(8'h14, 32'h3);
    wr(8'h10, 32'h3);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0, "irq cleared");
  endtask
  // third gap measured, the first two may be partial
  task automatic t_doze();
    logic [31:0] q;
    int k;
    for (int n = 0; n < 8; n++) begin
      wr(8'h04, {17'h0, n[2:0], 1'b1, 11'h0});
      for (int j = 0; j < 3; j++) begin
        k = 0;
        do begin
          @(posedge clk_i);
          k++;
        end while (cpu_clk_en_o !== 1'b1 && k < 300);
      end
      chk(k, 32'h1 << n, "doze period");
      rd(8'h04, q);
      chk(q, {17'h0, n[2:0], 1'b1, 11'h0}, "divider read");
      chk({27'h0, module_clk_en_o}, {27'h0, PRS}, "peripherals run");
    end
    cpu_irq <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(8'h04, q);
    chk(q, 32'h7800, "irq ignored without recover");
    cpu_irq <= 1'b0;
    wr(8'h04, 32'hB800);
    cpu_irq <= 1'b1;
    repeat (6) @(posedge clk_i);
    rd(8'h04, q);
    chk(q, 32'hB000, "recover on interrupt");
    repeat (4) @(posedge clk_i) chk({31'h0, cpu_clk_en_o}, 32'h1, "full speed");
    cpu_irq <= 1'b0;
    wr(8'h04, 32'h0);
  endtask
  task automatic t_mod();
    logic [31:0] q;
    wr(8'h08, 32'h1F);
    repeat (3) @(posedge clk_i);
    chk({27'h0, module_clk_en_o}, 32'h0, "modules gated");
    rd(8'h08, q);
    chk(q, 32'h1F, "disable read");
    wr(8'h08, 32'h0);
    repeat (3) @(posedge clk_i);
    chk({27'h0, module_clk_en_o}, {27'h0, PRS}, "modules back");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_switch();
    t_lock();
    t_pll();
    t_fail();
    t_irq();
    t_doze();
    t_mod();
    stop_test();
  end
endmodule // testbench
